// file: common/fpof_pkg.sv
/*
 * Package for the floating-point operand format unit: status register
 * layout, reset value, format widths, exponent bias and operation codes.
 * Assumes nothing of its surroundings.
 */
package fpof_pkg;
    localparam int unsigned FPOF_SHORT_INT_W = 16;
    localparam int unsigned FPOF_LONG_INT_W = 32;
    localparam int unsigned FPOF_SINGLE_W = 32;
    localparam int unsigned FPOF_DOUBLE_W = 64;
    localparam int unsigned FPOF_EXP_W = 8;
    localparam int unsigned FPOF_SINGLE_FRAC_W = 23;
    localparam int unsigned FPOF_DOUBLE_FRAC_W = 55;
    localparam logic [7:0] FPOF_EXP_BIAS = 8'h80;
    localparam logic [7:0] FPOF_EXP_ZERO = 8'h00;
    localparam logic [7:0] FPOF_EXP_MAX = 8'hff;
    localparam int unsigned FPOF_ACC_COUNT = 6;
    localparam int unsigned FPOF_XFER_ACC_COUNT = 4;
    localparam int unsigned FPOF_ACC_IDX_W = 3;

    // Internal fraction word: bit 63 overflow, bit 62 hidden bit
    localparam int unsigned FPOF_FRAC_OVF_BIT = 63;
    localparam int unsigned FPOF_FRAC_HID_BIT = 62;

    // Status register fields
    localparam int unsigned FPOF_ST_ERR = 15;
    localparam int unsigned FPOF_ST_INH = 14;
    localparam int unsigned FPOF_ST_PREC = 7;
    localparam int unsigned FPOF_ST_INTW = 6;
    localparam int unsigned FPOF_ST_TRUNC = 5;
    localparam int unsigned FPOF_ST_N = 3;
    localparam int unsigned FPOF_ST_Z = 2;
    localparam int unsigned FPOF_ST_V = 1;
    localparam int unsigned FPOF_ST_C = 0;
    localparam logic [15:0] FPOF_ST_RESET = 16'h0000;
    // Writable bits: 15,14,11..5,3..0 (12,13,4 unused, read zero)
    localparam logic [15:0] FPOF_ST_WMASK = 16'hcfef;

    typedef enum logic [3:0] {
        FPOF_OP_NOP,
        FPOF_OP_LOAD_FP,
        FPOF_OP_STORE_FP,
        FPOF_OP_LOAD_INT,
        FPOF_OP_STORE_INT,
        FPOF_OP_NEGATE,
        FPOF_OP_MOVE,
        FPOF_OP_NORMALIZE,
        FPOF_OP_WRITE_STATUS,
        FPOF_OP_READ_STATUS
    } fpof_op_e;
endpackage : fpof_pkg

// file: dv/fpof_host_model.sv
/* Host processor model: issues operations and drives initialize.
   Assumes its tasks are called from the bench at falling clock edges. */
`timescale 1ns/1ps
`default_nettype none
module fpof_host_model
    import fpof_pkg::*;
(
    input wire logic clock,
    output logic host_initialize_b,
    output logic op_valid,
    output logic [3:0] op_code,
    output logic [2:0] acc_dst,
    output logic [2:0] acc_src,
    output logic [63:0] op_data,
    output logic exception_event
);
    initial begin
        host_initialize_b = 1'b1;
        op_valid = 1'b0;
        op_code = 4'h0;
        acc_dst = 3'h0;
        acc_src = 3'h0;
        op_data = 64'h0;
        exception_event = 1'b0;
    end
    // Registers are only reached by issuing an operation
    task automatic issue(input logic [3:0] op, input logic [2:0] d, input logic [2:0] s,
        input logic [63:0] v);
        @(negedge clock);
        op_valid = 1'b1;
        op_code = op;
        acc_dst = d;
        acc_src = s;
        op_data = v;
        @(negedge clock);
        op_valid = 1'b0;
        op_data = ~v;
    endtask
    task automatic pulse_init(input int n);
        @(negedge clock);
        host_initialize_b = 1'b0;
        repeat (n) @(negedge clock);
        host_initialize_b = 1'b1;
    endtask
    task automatic pulse_event();
        @(negedge clock);
        exception_event = 1'b1;
        @(negedge clock);
        exception_event = 1'b0;
    endtask
endmodule // fpof_host_model
`default_nettype wire

// file: dv/fpof_monitor.sv
/* Checker of the operand unit: answers, refusals, status and interrupts.
   Bound to fpof_operand_unit; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module fpof_monitor
    import fpof_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic host_initialize_b,
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic [2:0] acc_dst,
    input wire logic [2:0] acc_src,
    input wire logic [63:0] op_data,
    input wire logic exception_event,
    input wire logic [63:0] result_data,
    input wire logic result_valid,
    input wire logic op_refused,
    input wire logic [15:0] fp_program_status,
    input wire logic interrupt_req
);
    logic [3:0] init_hist_r;
    logic quiet;
    logic is_store;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Initialize seen high long enough for its synchroniser to settle
    always_ff @(posedge clock) begin
        init_hist_r <= {init_hist_r[2:0], host_initialize_b};
    end
    assign quiet = host_initialize_b && (&init_hist_r) && !exception_event;
    assign is_store = op_code == FPOF_OP_STORE_FP || op_code == FPOF_OP_STORE_INT;
    status_write_a: assert property (op_valid && op_code == FPOF_OP_WRITE_STATUS && quiet
        |=> fp_program_status == ($past(op_data[63:48]) & FPOF_ST_WMASK)) else $error("status write wrong");
    status_hold_a: assert property (!op_valid && quiet |=> $stable(fp_program_status))
        else $error("status changed without operation");
    status_read_a: assert property (op_valid && op_code == FPOF_OP_READ_STATUS
        |=> result_valid && result_data[63:48] == $past(fp_program_status)) else $error("status read wrong");
    load_refuse_a: assert property (op_valid && acc_dst > 3'h3
        && (op_code == FPOF_OP_LOAD_FP || op_code == FPOF_OP_LOAD_INT) |=> op_refused && !result_valid)
        else $error("load to high accumulator taken");
    store_refuse_a: assert property (op_valid && is_store && acc_src > 3'h3
        |=> op_refused && !result_valid) else $error("store from high accumulator taken");
    store_answer_a: assert property (op_valid && is_store && acc_src <= 3'h3
        |=> result_valid && !op_refused) else $error("store not answered");
    move_legal_a: assert property (op_valid && op_code == FPOF_OP_MOVE
        && acc_dst <= 3'h5 && acc_src <= 3'h5 |=> !op_refused) else $error("legal move refused");
    irq_inhibit_a: assert property (interrupt_req |-> !$past(fp_program_status[FPOF_ST_INH]))
        else $error("interrupt while inhibited");
    init_clear_a: assert property ($fell(host_initialize_b)
        |-> ##[1:4] fp_program_status == FPOF_ST_RESET) else $error("initialize did not clear status");
    refuse_c: cover property (op_refused);
    irq_c: cover property (interrupt_req);
    init_c: cover property (!host_initialize_b ##1 host_initialize_b);
endmodule // fpof_monitor
`default_nettype wire

// file: dv/fpof_operand_unit_tb.sv
/* Self-checking bench of fpof_operand_unit with host model and checker.
   Assumes a 50 MHz clock and operations issued at falling edges. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin checked++; if ((a) !== (e)) begin bad_count++; $display("MISMATCH %0t %s", $time, m); end end
module fpof_operand_unit_tb
    import fpof_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic host_initialize_b, op_valid, exception_event, result_valid, op_refused, interrupt_req, got, refd;
    logic [3:0] op_code;
    logic [2:0] acc_dst, acc_src, d;
    logic [63:0] op_data, result_data, res, seed, a_val;
    logic [15:0] fp_program_status;
    int bad_count = 0;
    int checked = 0;
    always #10 clock = ~clock;
    fpof_host_model host (.clock(clock), .host_initialize_b(host_initialize_b), .op_valid(op_valid),
        .op_code(op_code), .acc_dst(acc_dst), .acc_src(acc_src), .op_data(op_data),
        .exception_event(exception_event));
    fpof_operand_unit uut (.clock(clock), .rst_b(rst_b), .host_initialize_b(host_initialize_b),
        .op_valid(op_valid), .op_code(op_code), .acc_dst(acc_dst), .acc_src(acc_src), .op_data(op_data),
        .exception_event(exception_event), .result_data(result_data), .result_valid(result_valid),
        .op_refused(op_refused), .fp_program_status(fp_program_status), .interrupt_req(interrupt_req));
    function automatic logic [63:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 7);
        seed = seed ^ (seed << 17);
        return seed;
    endfunction
    // Integer to double memory format, hidden bit dropped
    function automatic logic [63:0] i2f(input logic [31:0] i);
        logic [31:0] m;
        logic [63:0] f;
        int p;
        m = i[31] ? 32'(-i) : i;
        if (m == 32'h0) return 64'h0;
        p = 31;
        while (!m[p]) p--;
        f = {32'h0, m} & ((64'h1 << p) - 64'h1);
        return {i[31], 8'h80 + 8'(p + 1), 55'(f << (55 - p))};
    endfunction
    task automatic tally_and_finish();
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic run(input logic [3:0] op, input logic [2:0] dd, input logic [2:0] s, input logic [63:0] v);
        host.issue(op, dd, s, v);
        got = 1'b0;
        refd = 1'b0;
        repeat (3) begin
            if (!got && !refd) begin
                got = result_valid === 1'b1;
                refd = op_refused === 1'b1;
                res = result_data;
                if (!got && !refd) @(negedge clock);
            end
        end
        if ((op == FPOF_OP_STORE_FP || op == FPOF_OP_STORE_INT || op == FPOF_OP_READ_STATUS) && !got && !refd) begin
            bad_count++;
            $display("MISMATCH %0t no answer", $time);
            tally_and_finish();
        end
    endtask
    task automatic st(input logic [15:0] v);
        run(FPOF_OP_WRITE_STATUS, 3'h0, 3'h0, {v, 48'h0});
    endtask
    task automatic store_chk(input logic [2:0] s, input logic [63:0] e, input string m);
        run(FPOF_OP_STORE_FP, 3'h0, s, 64'h0);
        `CHK(res, e, m)
    endtask
    initial begin
        repeat (20000) @(negedge clock);
        bad_count++;
        $display("MISMATCH %0t timeout", $time);
        tally_and_finish();
    end
    initial begin
        seed = 64'h21;
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        @(negedge clock);
        `CHK(fp_program_status, FPOF_ST_RESET, "status reset")
        `CHK({result_valid, op_refused, interrupt_req}, 3'h0, "outputs idle")
        repeat (4) begin
            a_val = xs();
            st(a_val[15:0]);
            run(FPOF_OP_READ_STATUS, 3'h0, 3'h0, 64'h0);
            `CHK(res[63:48], a_val[15:0] & FPOF_ST_WMASK, "status write")
        end
        st(16'h0080);
        repeat (24) begin
            a_val = xs();
            d = {1'b0, a_val[5:4]};
            if (a_val[3:0] == 4'h0) a_val[62:55] = 8'h00;
            else if (a_val[62:55] == 8'h00) a_val[62:55] = 8'h01;
            run(FPOF_OP_LOAD_FP, d, 3'h0, a_val);
            if (a_val[6] && a_val[62:55] != 8'h00) begin
                run(FPOF_OP_NEGATE, d, d, 64'h0);
                a_val[63] = ~a_val[63];
            end
            store_chk(d, a_val[62:55] == 8'h00 ? 64'h0 : a_val, "fp round trip");
        end
        for (int w = 0; w < 2; w++) begin
            st(w ? 16'h00c0 : 16'h0080);
            for (int k = 0; k < 6; k++) begin
                a_val = k == 0 ? 64'h8000_8000 : k == 1 ? 64'h0 : xs();
                if (w == 0) a_val[31:0] = {{16{a_val[15]}}, a_val[15:0]};
                run(FPOF_OP_LOAD_INT, 3'h1, 3'h0, w ? {a_val[31:0], 32'h0} : {a_val[15:0], 48'h0});
                store_chk(3'h1, i2f(a_val[31:0]), "int load");
                run(FPOF_OP_STORE_INT, 3'h0, 3'h1, 64'h0);
                `CHK(w ? res[63:32] : {16'h0, res[63:48]}, w ? a_val[31:0] : {16'h0, a_val[15:0]}, "int store")
            end
        end
        st(16'h0080);
        run(FPOF_OP_LOAD_FP, 3'h2, 3'h0, 64'h4a00_0000_0000_0000);
        run(FPOF_OP_STORE_INT, 3'h0, 3'h2, 64'h0);
        `CHK({fp_program_status[15], fp_program_status[0]}, 2'h3, "conversion error")
        st(16'h0080);
        run(FPOF_OP_LOAD_FP, 3'h2, 3'h0, 64'h4123_4567_89ab_cdef);
        st(16'h0000);
        run(FPOF_OP_LOAD_FP, 3'h2, 3'h0, 64'hc080_0000_1111_1111);
        st(16'h0080);
        store_chk(3'h2, 64'hc080_0000_89ab_cdef, "upper half only");
        run(FPOF_OP_LOAD_FP, 3'h3, 3'h0, 64'h40c0_0000_8000_0000);
        for (int t = 0; t < 2; t++) begin
            st(t ? 16'h0020 : 16'h0000);
            run(FPOF_OP_STORE_FP, 3'h0, 3'h3, 64'h0);
            `CHK(res[63:32], t ? 32'h40c0_0000 : 32'h40c0_0001, "round or truncate")
        end
        st(16'h0080);
        a_val = 64'h4155_aaaa_5555_aaaa;
        run(FPOF_OP_LOAD_FP, 3'h0, 3'h0, a_val);
        run(FPOF_OP_MOVE, 3'h5, 3'h0, 64'h0);
        for (int i = 4; i < 8; i++) begin
            run(FPOF_OP_LOAD_FP, 3'(i), 3'h0, 64'h4000_0000_0000_0001);
            `CHK(refd, 1'b1, "load refused")
            run(FPOF_OP_STORE_FP, 3'h0, 3'(i), 64'h0);
            `CHK(refd, 1'b1, "store refused")
            if (i > 5) begin
                run(FPOF_OP_MOVE, 3'(i), 3'h0, 64'h0);
                `CHK(refd, 1'b1, "move refused")
            end
        end
        run(FPOF_OP_MOVE, 3'h3, 3'h5, 64'h0);
        store_chk(3'h3, a_val, "six accumulators");
        host.pulse_event();
        `CHK(interrupt_req, 1'b1, "interrupt raised")
        st(16'h4080);
        host.pulse_event();
        `CHK(interrupt_req, 1'b0, "interrupt inhibited")
        st(16'hcfef);
        host.pulse_init(1);
        repeat (4) @(negedge clock);
        run(FPOF_OP_READ_STATUS, 3'h0, 3'h0, 64'h0);
        `CHK(res[63:48], FPOF_ST_RESET, "initialize clears")
        st(16'h0080);
        store_chk(3'h3, a_val, "initialize keeps data");
        run(FPOF_OP_NORMALIZE, 3'h4, 3'h3, 64'hc000_0000_0000_0000);
        run(FPOF_OP_MOVE, 3'h2, 3'h4, 64'h0);
        store_chk(3'h2, 64'h41c0_0000_0000_0000, "overflow renormalized");
        run(FPOF_OP_NORMALIZE, 3'h2, 3'h3, 64'h0000_0000_0000_0180);
        store_chk(3'h2, 64'h2640_0000_0000_0000, "left normalized");
        tally_and_finish();
    end
endmodule // fpof_operand_unit_tb
bind fpof_operand_unit fpof_monitor mon (.clock(clock), .rst_b(rst_b), .host_initialize_b(host_initialize_b),
    .op_valid(op_valid), .op_code(op_code), .acc_dst(acc_dst), .acc_src(acc_src), .op_data(op_data),
    .exception_event(exception_event), .result_data(result_data), .result_valid(result_valid),
    .op_refused(op_refused), .fp_program_status(fp_program_status), .interrupt_req(interrupt_req));
`default_nettype wire

// file: verilog/fpof_normalizer.sv
/*
 * Normalizer for the internal 64-bit fraction word with overflow at bit 63
 * and hidden bit at bit 62. Combinational; the caller registers results.
 * Assumes an 8-bit excess-200 exponent beside the fraction.
 */
`timescale 1ns/1ps
`default_nettype none
module fpof_normalizer
    import fpof_pkg::*;
(
    input wire logic [63:0] frac_in,
    input wire logic [7:0] exp_in,
    output logic [63:0] frac_out,
    output logic [7:0] exp_out,
    output logic exp_overflow,
    output logic exp_underflow,
    output logic is_zero
);
    logic [6:0] lead;
    logic found;
    logic [8:0] exp_wide;

    always_comb begin
        lead = '0;
        found = 1'b0;
        for (int i = FPOF_FRAC_HID_BIT; i >= 0; i--) begin
            if (!found && frac_in[i]) begin
                lead = 7'(FPOF_FRAC_HID_BIT - i);
                found = 1'b1;
            end
        end
    end

    always_comb begin
        frac_out = frac_in;
        exp_wide = {1'b0, exp_in};
        exp_overflow = 1'b0;
        exp_underflow = 1'b0;
        is_zero = 1'b0;
        if (frac_in[FPOF_FRAC_OVF_BIT]) begin
            // Carry out: shift right once, bump exponent.
            frac_out = frac_in >> 1;
            exp_wide = {1'b0, exp_in} + 9'h001;
            exp_overflow = exp_wide[8];
        end else if (!found) begin
            // No set bit: result is true zero.
            frac_out = '0;
            exp_wide = {1'b0, FPOF_EXP_ZERO};
            is_zero = 1'b1;
        end else begin
            // Shift left until bit 62 is one, bit 63 zero.
            frac_out = frac_in << lead;
            exp_underflow = ({2'b00, lead} >= {1'b0, exp_in});
            exp_wide = {1'b0, exp_in} - {2'b00, lead};
        end
        exp_out = exp_wide[7:0];
        if (exp_underflow) begin
            frac_out = '0;
            exp_out = FPOF_EXP_ZERO;
            is_zero = 1'b1;
        end
    end
endmodule // fpof_normalizer
`default_nettype wire

// file: verilog/fpof_operand_unit.sv
/*
 * Operand format unit: six accumulators, program status register,
 * conversion between memory formats and the internal fraction word.
 * Assumes the host issues one operation per cycle on op_valid and that
 * registers are reached only through those operations.
 */
//
// Contract
// - Accept and produce 16-bit and 32-bit two's complement integers.
// - The integer word's most significant bit is its sign.
// - Single float is 32 bits, double 64, sign in the top bit.
// - Eight bits after sign hold exponent biased by 200 octal.
// - Fraction is 23 or 55 bits; with sign forms sign-magnitude.
// - Negation flips only the sign bit; code: an operand with exponent zero gives an all-zero word.
// - Normalize so bit 63 is zero and bit 62 is one.
// - Fraction overflow shifts right once and increments exponent.
// - Hidden bit dropped on store, reinserted on load.
// - Stored exponent zero means the value is zero.
// - Internal word keeps memory's sign, exponent and fraction values.
// - Single operations use upper accumulator half, lower half untouched; code: integer load and negate write all 64 bits.
// - All six accumulators compute; only first four transfer externally.
// - Status holds N, Z, V, C flags copyable to host codes.
// - Status bit 15 flags a detected error condition.
// - While status bit 14 is set no interrupt is raised.
// - Registers have no bus address; reached only by instructions.
// - Status bit 7 selects double precision when set.
// - Status bit 5 selects truncation over rounding.
`timescale 1ns/1ps
`default_nettype none
module fpof_operand_unit
    import fpof_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic host_initialize_b,
    input wire logic op_valid,
    input wire logic [3:0] op_code,
    input wire logic [2:0] acc_dst,
    input wire logic [2:0] acc_src,
    input wire logic [63:0] op_data,
    input wire logic exception_event,
    output logic [63:0] result_data,
    output logic result_valid,
    output logic op_refused,
    output logic [15:0] fp_program_status,
    output logic interrupt_req
);
    logic [63:0] accumulator_set [FPOF_ACC_COUNT];
    logic [15:0] status_r;
    logic [63:0] result_r;
    logic result_valid_r;
    logic refused_r;
    logic irq_r;
    logic init_s1_r;
    logic init_s2_r;

    logic precision_select;
    logic integer_width_select;
    logic truncate_select;
    logic all_interrupt_inhibit;
    fpof_op_e op;

    logic [63:0] src_word;
    logic src_sign;
    logic [7:0] src_exp;
    logic [63:0] src_frac;
    logic [63:0] load_frac;
    logic [63:0] norm_frac;
    logic [7:0] norm_exp;
    logic norm_ovf;
    logic norm_unf;
    logic norm_zero;
    logic [63:0] int_mag;
    logic int_sign;
    logic [7:0] int_exp;
    logic [63:0] packed_fp;
    logic [63:0] int_out;
    logic int_err;
    logic [54:0] frac_rounded;
    logic [55:0] round_sum;
    logic acc_write;
    logic [63:0] acc_wdata;
    logic [3:0] flags_nxt;
    logic err_event;
    logic access_ok;

    assign op = fpof_op_e'(op_code);
    assign precision_select = status_r[FPOF_ST_PREC];
    assign integer_width_select = status_r[FPOF_ST_INTW];
    assign truncate_select = status_r[FPOF_ST_TRUNC];
    assign all_interrupt_inhibit = status_r[FPOF_ST_INH];

    // Host initialize comes from another party: two-flop synchroniser
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            init_s1_r <= 1'b1;
            init_s2_r <= 1'b1;
        end else begin
            init_s1_r <= host_initialize_b;
            init_s2_r <= init_s1_r;
        end
    end

    // External transfers only via first four accumulators; internal use all six
    always_comb begin
        access_ok = (acc_dst < 3'(FPOF_ACC_COUNT)) && (acc_src < 3'(FPOF_ACC_COUNT));
        if ((op == FPOF_OP_LOAD_FP || op == FPOF_OP_LOAD_INT) && acc_dst >= 3'(FPOF_XFER_ACC_COUNT)) begin
            access_ok = 1'b0;
        end
        if ((op == FPOF_OP_STORE_FP || op == FPOF_OP_STORE_INT) && acc_src >= 3'(FPOF_XFER_ACC_COUNT)) begin
            access_ok = 1'b0;
        end
    end

    assign src_word = (acc_src < 3'(FPOF_ACC_COUNT)) ? accumulator_set[acc_src] : 64'h0;

    // Unpack memory operand into internal word, hidden bit restored
    always_comb begin
        src_sign = op_data[63];
        src_exp = op_data[62:55];
        if (src_exp == FPOF_EXP_ZERO) begin
            load_frac = '0;
        end else if (precision_select) begin
            load_frac = {2'b01, op_data[54:0], 7'h00};
        end else begin
            load_frac = {2'b01, op_data[54:32], 39'h0};
        end
    end

    // Integer to magnitude, sign from MSB of the chosen width
    always_comb begin
        if (integer_width_select) begin
            int_sign = op_data[63];
            int_mag = int_sign ? {-op_data[63:32], 32'h0} : {op_data[63:32], 32'h0};
        end else begin
            int_sign = op_data[63];
            int_mag = int_sign ? {-op_data[63:48], 48'h0} : {op_data[63:48], 48'h0};
        end
        // Magnitude sits as a fraction of 2^width: exponent is bias plus width
        int_exp = FPOF_EXP_BIAS + (integer_width_select ? 8'(FPOF_LONG_INT_W) : 8'(FPOF_SHORT_INT_W));
    end

    always_comb begin
        src_frac = load_frac;
        if (op == FPOF_OP_LOAD_INT) begin
            src_frac = int_mag >> 1;
        end else if (op == FPOF_OP_NORMALIZE) begin
            src_frac = op_data;
        end
    end

    fpof_normalizer u_norm (
        .frac_in(src_frac),
        .exp_in(op == FPOF_OP_LOAD_INT ? int_exp : (op == FPOF_OP_NORMALIZE ? src_word[62:55] : src_exp)),
        .frac_out(norm_frac),
        .exp_out(norm_exp),
        .exp_overflow(norm_ovf),
        .exp_underflow(norm_unf),
        .is_zero(norm_zero)
    );

    // Pack accumulator to memory: drop hidden bit, round or truncate
    always_comb begin
        round_sum = {1'b0, src_word[54:0]};
        if (!truncate_select && !precision_select) begin
            round_sum = {1'b0, src_word[54:0]} + 56'h0000_0080_0000_00;
        end
        frac_rounded = precision_select ? src_word[54:0] : {round_sum[54:32], 32'h0};
        packed_fp = {src_word[63:55], frac_rounded};
        if (round_sum[55] && !precision_select) begin
            packed_fp = {src_word[63], src_word[62:55] + 8'h01, 55'h0};
        end
        if (src_word[62:55] == FPOF_EXP_ZERO) begin
            packed_fp = '0;
        end
    end

    // Accumulator to integer; exponent overrange is a conversion error
    always_comb begin
        logic [63:0] mag;
        logic [7:0] shift;
        logic [7:0] int_w;
        mag = '0;
        shift = 8'h00;
        int_w = integer_width_select ? 8'(FPOF_LONG_INT_W) : 8'(FPOF_SHORT_INT_W);
        int_err = 1'b0;
        int_out = '0;
        if (src_word[62:55] > FPOF_EXP_BIAS) begin
            shift = src_word[62:55] - FPOF_EXP_BIAS;
            // Only the most negative integer reaches the full width
            if (shift > int_w || (shift == int_w && !(src_word[63] && src_word[54:0] == '0))) begin
                int_err = 1'b1;
            end else begin
                mag = {1'b1, src_word[54:0], 8'h00} >> (8'h40 - shift);
            end
        end
        if (!int_err) begin
            mag = src_word[63] ? -mag : mag;
            int_out = integer_width_select ? {mag[31:0], 32'h0} : {mag[15:0], 48'h0};
        end
    end

    // Datapath selection
    always_comb begin
        acc_write = 1'b0;
        acc_wdata = src_word;
        flags_nxt = status_r[3:0];
        err_event = 1'b0;
        if (op_valid && access_ok) begin
            case (op)
                FPOF_OP_LOAD_FP, FPOF_OP_LOAD_INT, FPOF_OP_NORMALIZE: begin
                    acc_write = 1'b1;
                    acc_wdata = {src_sign & ~norm_zero, norm_exp, norm_frac[61:7]};
                    if (op == FPOF_OP_LOAD_INT) begin
                        acc_wdata[63] = int_sign & ~norm_zero;
                    end else if (op == FPOF_OP_NORMALIZE) begin
                        acc_wdata[63] = src_word[63] & ~norm_zero;
                    end
                    if (!precision_select && op != FPOF_OP_LOAD_INT) begin
                        acc_wdata[31:0] = accumulator_set[acc_dst][31:0];
                    end
                    flags_nxt = {acc_wdata[63], norm_zero, norm_ovf, 1'b0};
                    err_event = norm_ovf | norm_unf;
                end
                FPOF_OP_NEGATE: begin
                    acc_write = 1'b1;
                    acc_wdata = src_word ^ {1'b1, 63'h0};
                    if (src_word[62:55] == FPOF_EXP_ZERO) begin
                        acc_wdata = '0;
                    end
                    flags_nxt = {acc_wdata[63], acc_wdata[62:55] == FPOF_EXP_ZERO, 2'b00};
                end
                FPOF_OP_MOVE: begin
                    acc_write = 1'b1;
                    acc_wdata = src_word;
                    if (!precision_select) begin
                        acc_wdata[31:0] = accumulator_set[acc_dst][31:0];
                    end
                end
                FPOF_OP_STORE_INT: begin
                    flags_nxt = {int_out[63], int_out == '0, 1'b0, int_err};
                    err_event = int_err;
                end
                default: begin
                end
            endcase
        end
    end

    // Accumulator file
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            for (int i = 0; i < FPOF_ACC_COUNT; i++) begin
                accumulator_set[i] <= '0;
            end
        end else if (acc_write) begin
            accumulator_set[acc_dst] <= acc_wdata;
        end
    end

    // Program status register; initialize clears it
    always_ff @(posedge clock) begin
        if (!rst_b || !init_s2_r) begin
            status_r <= FPOF_ST_RESET;
        end else if (op_valid && op == FPOF_OP_WRITE_STATUS) begin
            status_r <= op_data[63:48] & FPOF_ST_WMASK;
        end else begin
            status_r[3:0] <= flags_nxt;
            if (err_event) begin
                status_r[FPOF_ST_ERR] <= 1'b1;
            end
        end
    end

    // Results back to host, left-justified in 64 bits
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            result_r <= '0;
            result_valid_r <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            result_valid_r <= 1'b0;
            refused_r <= op_valid && !access_ok;
            if (op_valid && access_ok) begin
                case (op)
                    FPOF_OP_STORE_FP: begin
                        result_r <= precision_select ? packed_fp : {packed_fp[63:32], 32'h0};
                        result_valid_r <= 1'b1;
                    end
                    FPOF_OP_STORE_INT: begin
                        result_r <= int_out;
                        result_valid_r <= 1'b1;
                    end
                    FPOF_OP_READ_STATUS: begin
                        result_r <= {status_r, 48'h0};
                        result_valid_r <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Interrupt request held off while inhibit is set
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (exception_event | err_event) & ~all_interrupt_inhibit;
        end
    end

    assign result_data = result_r;
    assign result_valid = result_valid_r;
    assign op_refused = refused_r;
    assign fp_program_status = status_r;
    assign interrupt_req = irq_r;
endmodule // fpof_operand_unit
`default_nettype wire
